// ===== design/gate_driver_config_regs.sv
// Serial-access configuration and fault status register bank of a dual bridge gate driver
// Behaviour
// - Reset loads every register with its default before any host access.
// - Control bit 0 enables motor outputs; default enabled.
// - Control bits 9-8 select sense gain 5/10/20/40; default 11.
// - Control bits 11-10 select added dead time; default 00.
// - Current-scale bits 7-0 set full-scale current; reset all ones.
// - Off-time bits 7-0 in 525 ns steps; default 0x30.
// - Blanking bits 7-0 in 21 ns steps, floor up to 0x32; default 0x80.
// - Blanking value also sets minimum on-time of each drive phase.
// - Decay-timing bits 7-0 in 525 ns steps; default 0x10.
// - Decay select bits 10-8 pick slow, fast, mixed, auto mixed; default 000.
// - Drive bits 1-0 set overcurrent threshold; default 01.
// - Drive bits 3-2 set overcurrent deglitch time; default 01.
// - Drive bits 5-4 set gate sink drive time; default 10.
// - Drive bits 7-6 set gate source drive time; default 10.
// - Drive bits 9-8 set peak sink current; default 11.
// - Drive bits 11-10 set peak source current; default 11.
// - Status bit 0 follows overtemperature and clears itself.
// - Status bits 1-2 latch overcurrent per channel until written zero.
// - Status bits 3-4 latch predriver fault per channel until written zero.
// - Status bit 5 latches undervoltage; zero write ignored during sleep.
// - Operation resumes alone once supply is back above threshold.
// - Frame is 16 bits: read/write, three address, twelve data; 1 reads.
// - Overcurrent disables that bridge and pulls the fault output low.
module gate_driver_config_regs
    import gate_drv_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic link_select_in,
    input wire logic link_clock_in,
    input wire logic link_data_in,
    output logic link_data_out,
    input wire logic sleep_request_low_in,
    input wire logic overtemp_in,
    input wire logic undervoltage_in,
    input wire logic chan_a_overcurrent_in,
    input wire logic chan_b_overcurrent_in,
    input wire logic chan_a_predriver_fault_in,
    input wire logic chan_b_predriver_fault_in,
    output logic motor_output_enable_out,
    output logic [1:0] sense_amp_gain_out,
    output logic [1:0] dead_time_select_out,
    output logic [7:0] full_scale_current_out,
    output logic [7:0] fixed_off_time_out,
    output logic pulse_control_select_out,
    output logic [7:0] trip_blanking_time_out,
    output logic [7:0] min_on_time_out,
    output logic [7:0] mixed_decay_time_out,
    output logic [2:0] decay_select_out,
    output logic [1:0] overcurrent_threshold_out,
    output logic [1:0] overcurrent_deglitch_out,
    output logic [1:0] sink_drive_time_out,
    output logic [1:0] source_drive_time_out,
    output logic [1:0] sink_peak_current_out,
    output logic [1:0] source_peak_current_out,
    output logic bridge_a_enable_out,
    output logic bridge_b_enable_out,
    output logic fault_out_low_out
);
    import gate_drv_pkg::*;

    // Sticky flag update: a set in the clearing cycle wins
    function automatic logic sticky_next(input logic flag, input logic set,
                                         input logic clear);
        sticky_next = set | (flag & ~clear);
    endfunction

    // Synchronisers; stage 0 feeds only stage 1, stage 2 is the edge history
    logic [2:0] sel_sync_r;
    logic [2:0] clk_sync_r;
    logic [1:0] din_sync_r;
    logic [1:0] sleep_sync_r;
    logic [1:0] ot_sync_r;
    logic [1:0] uv_sync_r;
    logic [1:0] oca_sync_r;
    logic [1:0] ocb_sync_r;
    logic [1:0] pdfa_sync_r;
    logic [1:0] pdfb_sync_r;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sel_sync_r <= 3'h0;
            clk_sync_r <= 3'h0;
            din_sync_r <= 2'h0;
            sleep_sync_r <= 2'h0;
            ot_sync_r <= 2'h0;
            uv_sync_r <= 2'h0;
            oca_sync_r <= 2'h0;
            ocb_sync_r <= 2'h0;
            pdfa_sync_r <= 2'h0;
            pdfb_sync_r <= 2'h0;
        end else begin
            sel_sync_r <= {sel_sync_r[1:0], link_select_in};
            clk_sync_r <= {clk_sync_r[1:0], link_clock_in};
            din_sync_r <= {din_sync_r[0], link_data_in};
            sleep_sync_r <= {sleep_sync_r[0], sleep_request_low_in};
            ot_sync_r <= {ot_sync_r[0], overtemp_in};
            uv_sync_r <= {uv_sync_r[0], undervoltage_in};
            oca_sync_r <= {oca_sync_r[0], chan_a_overcurrent_in};
            ocb_sync_r <= {ocb_sync_r[0], chan_b_overcurrent_in};
            pdfa_sync_r <= {pdfa_sync_r[0], chan_a_predriver_fault_in};
            pdfb_sync_r <= {pdfb_sync_r[0], chan_b_predriver_fault_in};
        end
    end

    logic sel_active;
    logic sclk_rise;
    logic sclk_fall;
    logic din_bit;
    logic awake;
    assign sel_active = sel_sync_r[1];
    assign sclk_rise = clk_sync_r[1] & ~clk_sync_r[2];
    assign sclk_fall = ~clk_sync_r[1] & clk_sync_r[2];
    assign din_bit = din_sync_r[1];
    assign awake = sleep_sync_r[1];

    // Serial frame engine
    link_state_t state_r;
    logic [4:0] bit_cnt_r;
    logic [FRAME_W-1:0] rx_r;
    logic [DATA_W-1:0] tx_r;
    logic [DATA_W-1:0] read_word;
    logic [ADDR_W-1:0] live_addr;
    logic [ADDR_W-1:0] frame_addr;
    logic wr_commit;
    logic take_bit;

    assign take_bit = (state_r == LINK_SHIFT) && sclk_rise && (bit_cnt_r < FRAME_BITS);
    assign live_addr = {rx_r[1:0], din_bit};
    assign frame_addr = rx_r[DATA_W +: ADDR_W];
    // Write lands only when a full frame ends with a leading zero
    assign wr_commit = (state_r == LINK_SHIFT) && !sel_active
        && (bit_cnt_r == FRAME_BITS) && !rx_r[FRAME_RW_BIT];

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= LINK_IDLE;
        end else begin
            unique case (state_r)
                LINK_IDLE: begin
                    if (sel_active) begin
                        state_r <= LINK_SHIFT;
                    end
                end
                LINK_SHIFT: begin
                    if (!sel_active) begin
                        state_r <= LINK_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bit_cnt_r <= 5'h00;
            rx_r <= 16'h0000;
        end else if (state_r == LINK_IDLE) begin
            bit_cnt_r <= 5'h00;
        end else if (take_bit) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            rx_r <= {rx_r[FRAME_W-2:0], din_bit};
        end
    end

    // Read data loaded once the address is complete, shifted out on falling edges
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_r <= 12'h000;
            link_data_out <= 1'b0;
        end else if (state_r == LINK_IDLE) begin
            tx_r <= 12'h000;
            link_data_out <= 1'b0;
        end else if (take_bit && bit_cnt_r == ADDR_DONE_CNT) begin
            tx_r <= rx_r[2] ? read_word : 12'h000;
        end else if (sclk_fall && bit_cnt_r >= DATA_FIRST_CNT
                     && bit_cnt_r <= DATA_LAST_CNT) begin
            link_data_out <= tx_r[DATA_W-1];
            tx_r <= {tx_r[DATA_W-2:0], 1'b0};
        end
    end

    // Configuration registers
    logic [DATA_W-1:0] ctrl_r;
    logic [DATA_W-1:0] scale_r;
    logic [DATA_W-1:0] off_r;
    logic [DATA_W-1:0] blank_r;
    logic [DATA_W-1:0] decay_r;
    logic [DATA_W-1:0] drive_r;

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctrl_r <= RST_CONTROL_CONFIG;
            scale_r <= RST_FULL_SCALE_CURRENT;
            off_r <= RST_OFF_TIME_CONFIG;
            blank_r <= RST_BLANKING_CONFIG;
            decay_r <= RST_DECAY_CONFIG;
            drive_r <= RST_GATE_DRIVE_CONFIG;
        end else if (wr_commit) begin
            unique case (frame_addr)
                ADDR_CONTROL_CONFIG: ctrl_r <= rx_r[DATA_W-1:0] & MASK_CONTROL_CONFIG;
                ADDR_FULL_SCALE_CURRENT: scale_r <= rx_r[DATA_W-1:0] & MASK_FULL_SCALE_CURRENT;
                // Host is expected to keep the pulse control bit set
                ADDR_OFF_TIME_CONFIG: off_r <= rx_r[DATA_W-1:0] & MASK_OFF_TIME_CONFIG;
                ADDR_BLANKING_CONFIG: blank_r <= rx_r[DATA_W-1:0] & MASK_BLANKING_CONFIG;
                ADDR_DECAY_CONFIG: decay_r <= rx_r[DATA_W-1:0] & MASK_DECAY_CONFIG;
                ADDR_GATE_DRIVE_CONFIG: drive_r <= rx_r[DATA_W-1:0] & MASK_GATE_DRIVE_CONFIG;
                ADDR_RESERVED_SLOT, ADDR_FAULT_STATUS: begin
                end
            endcase
        end
    end

    // Blanking floor, also used as minimum on-time
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            min_on_time_out <= RST_BLANKING_CONFIG[7:0];
        end else if (blank_r[7:0] <= BLANK_FLOOR_CODE) begin
            min_on_time_out <= BLANK_FLOOR_CODE;
        end else begin
            min_on_time_out <= blank_r[7:0];
        end
    end

    // Fault flags
    logic ot_flag_r;
    logic oca_flag_r;
    logic ocb_flag_r;
    logic pdfa_flag_r;
    logic pdfb_flag_r;
    logic uv_flag_r;
    logic status_write;
    assign status_write = wr_commit && (frame_addr == ADDR_FAULT_STATUS);

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ot_flag_r <= 1'b0;
        end else begin
            ot_flag_r <= ot_sync_r[1];
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            oca_flag_r <= 1'b0;
            ocb_flag_r <= 1'b0;
        end else begin
            oca_flag_r <= sticky_next(oca_flag_r, oca_sync_r[1],
                                      status_write && !rx_r[ST_OC_A_BIT]);
            ocb_flag_r <= sticky_next(ocb_flag_r, ocb_sync_r[1],
                                      status_write && !rx_r[ST_OC_B_BIT]);
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pdfa_flag_r <= 1'b0;
            pdfb_flag_r <= 1'b0;
        end else begin
            pdfa_flag_r <= sticky_next(pdfa_flag_r, pdfa_sync_r[1],
                                       status_write && !rx_r[ST_PDF_A_BIT]);
            pdfb_flag_r <= sticky_next(pdfb_flag_r, pdfb_sync_r[1],
                                       status_write && !rx_r[ST_PDF_B_BIT]);
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            uv_flag_r <= 1'b0;
        end else begin
            uv_flag_r <= sticky_next(uv_flag_r, uv_sync_r[1],
                                     status_write && awake && !rx_r[ST_UNDERVOLT_BIT]);
        end
    end

    // Register read mux; reserved slot and reserved bits read zero
    always_comb begin
        read_word = 12'h000;
        unique case (live_addr)
            ADDR_CONTROL_CONFIG: read_word = ctrl_r;
            ADDR_FULL_SCALE_CURRENT: read_word = scale_r;
            ADDR_OFF_TIME_CONFIG: read_word = off_r;
            ADDR_BLANKING_CONFIG: read_word = blank_r;
            ADDR_DECAY_CONFIG: read_word = decay_r;
            ADDR_RESERVED_SLOT: read_word = 12'h000;
            ADDR_GATE_DRIVE_CONFIG: read_word = drive_r;
            ADDR_FAULT_STATUS: begin
                read_word[ST_OVERTEMP_BIT] = ot_flag_r;
                read_word[ST_OC_A_BIT] = oca_flag_r;
                read_word[ST_OC_B_BIT] = ocb_flag_r;
                read_word[ST_PDF_A_BIT] = pdfa_flag_r;
                read_word[ST_PDF_B_BIT] = pdfb_flag_r;
                read_word[ST_UNDERVOLT_BIT] = uv_flag_r;
            end
        endcase
    end

    // Bridge gating and fault indication
    logic global_ok;
    // Supply and temperature gating follow the live levels, so recovery is automatic
    assign global_ok = ctrl_r[MOTOR_ENABLE_BIT] && awake && !ot_sync_r[1]
        && !uv_sync_r[1];

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bridge_a_enable_out <= 1'b0;
            bridge_b_enable_out <= 1'b0;
            fault_out_low_out <= 1'b1;
        end else begin
            bridge_a_enable_out <= global_ok && !oca_flag_r && !oca_sync_r[1]
                && !pdfa_flag_r && !pdfa_sync_r[1];
            bridge_b_enable_out <= global_ok && !ocb_flag_r && !ocb_sync_r[1]
                && !pdfb_flag_r && !pdfb_sync_r[1];
            fault_out_low_out <= !(ot_sync_r[1] || uv_sync_r[1] || oca_flag_r
                || ocb_flag_r || pdfa_flag_r || pdfb_flag_r
                || oca_sync_r[1] || ocb_sync_r[1]);
        end
    end

    // Setting fields straight from the register flops
    assign motor_output_enable_out = ctrl_r[MOTOR_ENABLE_BIT];
    assign sense_amp_gain_out = ctrl_r[GAIN_LSB +: 2];
    assign dead_time_select_out = ctrl_r[DEAD_TIME_LSB +: 2];
    assign full_scale_current_out = scale_r[7:0];
    assign fixed_off_time_out = off_r[7:0];
    assign pulse_control_select_out = off_r[PULSE_CONTROL_BIT];
    assign trip_blanking_time_out = blank_r[7:0];
    assign mixed_decay_time_out = decay_r[7:0];
    assign decay_select_out = decay_r[DECAY_SELECT_LSB +: 3];
    assign overcurrent_threshold_out = drive_r[OC_THRESHOLD_LSB +: 2];
    assign overcurrent_deglitch_out = drive_r[OC_DEGLITCH_LSB +: 2];
    assign sink_drive_time_out = drive_r[SINK_TIME_LSB +: 2];
    assign source_drive_time_out = drive_r[SOURCE_TIME_LSB +: 2];
    assign sink_peak_current_out = drive_r[SINK_PEAK_LSB +: 2];
    assign source_peak_current_out = drive_r[SOURCE_PEAK_LSB +: 2];

endmodule // gate_driver_config_regs

// ===== design/gate_drv_pkg.sv
// Constants for the gate driver configuration and fault register bank
package gate_drv_pkg;

    localparam int DATA_W = 12;
    localparam int ADDR_W = 3;
    localparam int FRAME_W = 16;

    // Serial frame layout, first bit shifted in is the read/write bit
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_DONE_CNT = 5'h03;
    localparam logic [4:0] DATA_FIRST_CNT = 5'h04;
    localparam logic [4:0] DATA_LAST_CNT = 5'h0F;
    localparam int FRAME_RW_BIT = 15;

    // Register offsets
    localparam logic [2:0] ADDR_CONTROL_CONFIG = 3'h0;
    localparam logic [2:0] ADDR_FULL_SCALE_CURRENT = 3'h1;
    localparam logic [2:0] ADDR_OFF_TIME_CONFIG = 3'h2;
    localparam logic [2:0] ADDR_BLANKING_CONFIG = 3'h3;
    localparam logic [2:0] ADDR_DECAY_CONFIG = 3'h4;
    localparam logic [2:0] ADDR_RESERVED_SLOT = 3'h5;
    localparam logic [2:0] ADDR_GATE_DRIVE_CONFIG = 3'h6;
    localparam logic [2:0] ADDR_FAULT_STATUS = 3'h7;

    // Reset values
    localparam logic [11:0] RST_CONTROL_CONFIG = 12'h301;
    localparam logic [11:0] RST_FULL_SCALE_CURRENT = 12'h0FF;
    localparam logic [11:0] RST_OFF_TIME_CONFIG = 12'h130;
    localparam logic [11:0] RST_BLANKING_CONFIG = 12'h080;
    localparam logic [11:0] RST_DECAY_CONFIG = 12'h010;
    localparam logic [11:0] RST_GATE_DRIVE_CONFIG = 12'hFA5;

    // Implemented bits; reserved bits store nothing and read zero
    localparam logic [11:0] MASK_CONTROL_CONFIG = 12'hF01;
    localparam logic [11:0] MASK_FULL_SCALE_CURRENT = 12'h0FF;
    localparam logic [11:0] MASK_OFF_TIME_CONFIG = 12'h1FF;
    localparam logic [11:0] MASK_BLANKING_CONFIG = 12'h0FF;
    localparam logic [11:0] MASK_DECAY_CONFIG = 12'h7FF;
    localparam logic [11:0] MASK_GATE_DRIVE_CONFIG = 12'hFFF;

    // Field positions
    localparam int MOTOR_ENABLE_BIT = 0;
    localparam int GAIN_LSB = 8;
    localparam int DEAD_TIME_LSB = 10;
    localparam int PULSE_CONTROL_BIT = 8;
    localparam int DECAY_SELECT_LSB = 8;
    localparam int OC_THRESHOLD_LSB = 0;
    localparam int OC_DEGLITCH_LSB = 2;
    localparam int SINK_TIME_LSB = 4;
    localparam int SOURCE_TIME_LSB = 6;
    localparam int SINK_PEAK_LSB = 8;
    localparam int SOURCE_PEAK_LSB = 10;
    localparam int ST_OVERTEMP_BIT = 0;
    localparam int ST_OC_A_BIT = 1;
    localparam int ST_OC_B_BIT = 2;
    localparam int ST_PDF_A_BIT = 3;
    localparam int ST_PDF_B_BIT = 4;
    localparam int ST_UNDERVOLT_BIT = 5;

    // Blanking codes at or below this give the floor time
    localparam logic [7:0] BLANK_FLOOR_CODE = 8'h32;

    typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_t;

endpackage

// ===== verif/host_link_model.sv
// Host model that sends serial frames to the register bank
module host_link_model
    import gate_drv_pkg::*;
(
    input logic core_clk_in,
    input logic link_data_in,
    output logic link_select_out,
    output logic link_clock_out,
    output logic link_data_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        link_select_out = 1'b0;
        link_clock_out = 1'b0;
        link_data_out = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask

    // Link clock idles low; fewer than 16 bits makes a short frame
    task automatic frame(input logic [15:0] word, input int nbits, output logic [11:0] rd);
        rd = 12'h000;
        link_select_out = 1'b1;
        tick(20);
        for (int i = 0; i < nbits; i++) begin
            link_data_out = word[15 - i];
            tick(20);
            if (i >= 4) rd[15 - i] = link_data_in;
            link_clock_out = 1'b1;
            tick(20);
            link_clock_out = 1'b0;
        end
        tick(20);
        link_select_out = 1'b0;
        // Released line shows the inverse of its last bit
        link_data_out = ~link_data_out;
        tick(20);
    endtask

    task automatic write_reg(input logic [2:0] addr, input logic [11:0] data);
        logic [11:0] unused;
        if (addr == ADDR_OFF_TIME_CONFIG) data[PULSE_CONTROL_BIT] = 1'b1;
        frame({1'b0, addr, data}, FRAME_W, unused);
    endtask

    task automatic read_reg(input logic [2:0] addr, output logic [11:0] data);
        frame({1'b1, addr, 12'h000}, FRAME_W, data);
    endtask
endmodule // host_link_model

// ===== verif/gate_driver_config_regs_chk.sv
// Port-level checks on the register bank
module gate_driver_config_regs_chk
    import gate_drv_pkg::*;
(
    input logic core_clk_in,
    input logic nrst_in,
    input logic link_select_in,
    input logic link_data_out,
    input logic overtemp_in,
    input logic undervoltage_in,
    input logic chan_a_overcurrent_in,
    input logic chan_b_overcurrent_in,
    input logic chan_b_predriver_fault_in,
    input logic motor_output_enable_out,
    input logic [7:0] full_scale_current_out,
    input logic [7:0] trip_blanking_time_out,
    input logic [7:0] min_on_time_out,
    input logic [2:0] decay_select_out,
    input logic bridge_a_enable_out,
    input logic bridge_b_enable_out,
    input logic fault_out_low_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    reset_vals_a: assert property (disable iff (1'b0)
        !nrst_in && $past(!nrst_in) |-> motor_output_enable_out && fault_out_low_out
        && full_scale_current_out == 8'hFF && !bridge_a_enable_out)
        else $error("outputs not at defaults during reset");
    min_on_floor_a: assert property (min_on_time_out == (($past(trip_blanking_time_out)
        > 8'h32) ? $past(trip_blanking_time_out) : 8'h32))
        else $error("minimum on-time does not follow blanking floor");
    oc_a_trip_a: assert property ($rose(chan_a_overcurrent_in) |-> ##[2:6]
        (!bridge_a_enable_out && !fault_out_low_out)) else $error("bridge A not tripped");
    oc_b_hold_a: assert property (chan_b_overcurrent_in [*4] |->
        !bridge_b_enable_out && !fault_out_low_out) else $error("bridge B runs in overcurrent");
    pdf_b_hold_a: assert property ($fell(chan_b_predriver_fault_in) |-> ##4
        !bridge_b_enable_out [*8]) else $error("predriver fault did not latch");
    overtemp_stop_a: assert property (overtemp_in [*5] |-> !bridge_a_enable_out
        && !bridge_b_enable_out && !fault_out_low_out) else $error("running while hot");
    undervolt_stop_a: assert property (undervoltage_in [*5] |-> !bridge_a_enable_out
        && !bridge_b_enable_out && !fault_out_low_out) else $error("running in undervoltage");
    idle_quiet_a: assert property (!link_select_in [*8] |-> !link_data_out)
        else $error("read data line not low outside frames");
    frame_hold_a: assert property (link_select_in [*8] |-> $stable(full_scale_current_out)
        && $stable(decay_select_out) && $stable(motor_output_enable_out))
        else $error("register changed in mid-frame");
endmodule // gate_driver_config_regs_chk

bind gate_driver_config_regs gate_driver_config_regs_chk i_gate_driver_config_regs_chk (
    .core_clk_in, .nrst_in, .link_select_in, .link_data_out, .overtemp_in,
    .undervoltage_in, .chan_a_overcurrent_in, .chan_b_overcurrent_in,
    .chan_b_predriver_fault_in, .motor_output_enable_out, .full_scale_current_out,
    .trip_blanking_time_out, .min_on_time_out, .decay_select_out, .bridge_a_enable_out,
    .bridge_b_enable_out, .fault_out_low_out
);

// ===== verif/tb_gate_driver_config_regs.sv
// Self-checking bench for the gate driver register bank
module tb_gate_driver_config_regs;
    import gate_drv_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_in, nrst_in, link_select_in, link_clock_in, link_data_in, link_data_out;
    logic sleep_request_low_in, overtemp_in, undervoltage_in, motor_output_enable_out;
    logic pulse_control_select_out, bridge_a_enable_out, bridge_b_enable_out, fault_out_low_out;
    logic [3:0] ev;
    logic chan_a_overcurrent_in, chan_b_overcurrent_in, chan_a_predriver_fault_in;
    logic chan_b_predriver_fault_in;
    logic [1:0] sense_amp_gain_out, dead_time_select_out, overcurrent_threshold_out;
    logic [1:0] overcurrent_deglitch_out, sink_drive_time_out, source_drive_time_out;
    logic [1:0] sink_peak_current_out, source_peak_current_out;
    logic [2:0] decay_select_out;
    logic [7:0] full_scale_current_out, fixed_off_time_out, trip_blanking_time_out;
    logic [7:0] min_on_time_out, mixed_decay_time_out;
    logic [11:0] exp_r [8];
    logic [11:0] mask [8] = '{12'hF01, 12'h0FF, 12'h1FF, 12'h0FF,
        12'h7FF, 12'h000, 12'hFFF, 12'h000};
    logic [11:0] dflt [8] = '{12'h301, 12'h0FF, 12'h130, 12'h080,
        12'h010, 12'h000, 12'hFA5, 12'h000};
    logic [11:0] pat [4] = '{12'h000, 12'hA33, 12'h532, 12'hBFF};
    logic [11:0] rd;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;

    assign {chan_b_predriver_fault_in, chan_a_predriver_fault_in, chan_b_overcurrent_in,
        chan_a_overcurrent_in} = ev;

    gate_driver_config_regs i_gate_driver_config_regs (
        .core_clk_in, .nrst_in, .link_select_in, .link_clock_in, .link_data_in,
        .link_data_out, .sleep_request_low_in, .overtemp_in, .undervoltage_in,
        .chan_a_overcurrent_in, .chan_b_overcurrent_in,
        .chan_a_predriver_fault_in, .chan_b_predriver_fault_in,
        .motor_output_enable_out, .sense_amp_gain_out, .dead_time_select_out,
        .full_scale_current_out, .fixed_off_time_out, .pulse_control_select_out,
        .trip_blanking_time_out, .min_on_time_out, .mixed_decay_time_out, .decay_select_out,
        .overcurrent_threshold_out, .overcurrent_deglitch_out, .sink_drive_time_out,
        .source_drive_time_out, .sink_peak_current_out, .source_peak_current_out,
        .bridge_a_enable_out, .bridge_b_enable_out, .fault_out_low_out
    );
    host_link_model i_host_link_model (
        .core_clk_in, .link_data_in(link_data_out), .link_select_out(link_select_in),
        .link_clock_out(link_clock_in), .link_data_out(link_data_in)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic read_chk(input int a, input logic [11:0] want);
        i_host_link_model.read_reg(a[2:0], rd);
        check(rd, want);
    endtask

    task automatic pins(input logic [2:0] want);
        check({9'h000, fault_out_low_out, bridge_b_enable_out, bridge_a_enable_out},
            {9'h000, want});
    endtask

    task automatic check_regs();
        for (int a = 0; a < 8; a++) read_chk(a, exp_r[a]);
    endtask

    task automatic check_fields();
        check({dead_time_select_out, sense_amp_gain_out, 7'h00, motor_output_enable_out},
            exp_r[0] & 12'hF01);
        check({4'h0, full_scale_current_out}, exp_r[1] & 12'h0FF);
        check({3'h0, pulse_control_select_out, fixed_off_time_out}, exp_r[2]);
        check({4'h0, trip_blanking_time_out}, exp_r[3]);
        check({4'h0, min_on_time_out},
            {4'h0, (exp_r[3][7:0] > 8'h32) ? exp_r[3][7:0] : 8'h32});
        check({1'b0, decay_select_out, mixed_decay_time_out}, exp_r[4]);
        check({source_peak_current_out, sink_peak_current_out, source_drive_time_out,
            sink_drive_time_out, overcurrent_deglitch_out, overcurrent_threshold_out},
            exp_r[6]);
    endtask

    initial begin
        nrst_in = 1'b0;
        sleep_request_low_in = 1'b1;
        overtemp_in = 1'b0;
        undervoltage_in = 1'b0;
        ev = 4'h0;
        exp_r = dflt;
        repeat (12) @(posedge core_clk_in);
        #1 nrst_in = 1'b1;
        check_fields();
        check_regs();
        foreach (pat[p]) begin
            for (int a = 0; a < 7; a++) begin
                i_host_link_model.write_reg(a[2:0], pat[p]);
                exp_r[a] = pat[p] & mask[a];
            end
            exp_r[2][8] = 1'b1;
            check_regs();
            check_fields();
        end
        i_host_link_model.tick(200);
        pins(3'b111);
        for (int e = 0; e < 4; e++) begin
            ev[e] = 1'b1;
            i_host_link_model.tick(4);
            ev[e] = 1'b0;
            i_host_link_model.tick(6);
            pins({1'b0, ~e[0], e[0]});
            i_host_link_model.write_reg(3'h7, 12'hFFF);
            read_chk(7, 12'h002 << e);
            i_host_link_model.write_reg(3'h7, 12'h000);
            read_chk(7, 12'h000);
            pins(3'b111);
        end
        overtemp_in = 1'b1;
        i_host_link_model.tick(6);
        pins(3'b000);
        read_chk(7, 12'h001);
        overtemp_in = 1'b0;
        i_host_link_model.tick(6);
        pins(3'b111);
        read_chk(7, 12'h000);
        undervoltage_in = 1'b1;
        i_host_link_model.tick(6);
        pins(3'b000);
        undervoltage_in = 1'b0;
        i_host_link_model.tick(6);
        pins(3'b111);
        sleep_request_low_in = 1'b0;
        i_host_link_model.write_reg(3'h7, 12'h000);
        read_chk(7, 12'h020);
        sleep_request_low_in = 1'b1;
        i_host_link_model.write_reg(3'h7, 12'h000);
        read_chk(7, 12'h000);
        i_host_link_model.frame({1'b0, 3'h1, 12'h000}, 8, rd);
        read_chk(1, exp_r[1]);
        // Mid-run reset must bring back every default
        nrst_in = 1'b0;
        i_host_link_model.tick(3);
        nrst_in = 1'b1;
        exp_r = dflt;
        pins(3'b100);
        check_fields();
        check_regs();
        wrap_up();
    end

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 90000) begin
            err_total++;
            wrap_up();
        end
    end
endmodule // tb_gate_driver_config_regs
